// [design/ppx_i2c_slave.v]
// i2c slave front end with register file, reload and recovery behaviour
// Functional notes
// RL1: a start or stop condition returns the serial logic to its initial state.
// RL2: a transfer cut off without start or stop leaves the protocol state as it was.
// RL3: while driving the data line low the slave ignores start and stop but still advances on clock edges.
// RL4: a start attempted while the slave holds data low is not taken as a start.
// RL5: the master recovers the slave with a start, 27 clocks and data left high.
// RL6: once the clocks let the slave release data, a stop makes it accept transfers again.
// RL7: the master should run the recovery sequence after its own power-up.
// RL8: a low-supply indication resets the internal logic with no bus action.
// RL9: during power-on initialization all bus instructions are ignored.
// RL10: after successful initialization the slave enters standby and waits for the bus.
// RL11: clock and data inputs reject glitches narrower than about 130 ns.
// RL12: shipped contents are D4H control, FFH range select and 00H for four delay words.
// RL13: a one in the range select word picks the short range, zero the long range.
// RL14: a delay word holds one bit set for the chosen delay and zeros elsewhere.
// RL15: after power-on or low-supply recovery nonvolatile contents load before timers run.
// RL16: after any internal reset data is released and the slave idles until a start.
`timescale 1ns/1ps
`default_nettype none
`include "ppx_map.vh"
module ppx_i2c_slave #(
  parameter [6:0]  DEV_ADDR   = 7'h2A,            // arbitrary bus address
  parameter [15:0] INIT_CYCLES = `PPX_INIT_CYCLES_DEF
) (
  // clock and reset
  input  wire       clock,
  input  wire       rst_n,
  // supply monitor
  input  wire       low_supply,
  // i2c pins
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  // status and working registers
  output reg        init_done,
  output reg  [7:0] output_port_control_reg,
  output reg  [7:0] timer_range_select_reg,
  output reg  [7:0] channel0_delay_select_reg,
  output reg  [7:0] channel1_delay_select_reg,
  output reg  [7:0] channel2_delay_select_reg,
  output reg  [7:0] channel3_delay_select_reg,
  output wire [3:0] channel_short_range
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_ADDR = 6'b000010;
  localparam [5:0] ST_AACK = 6'b000100;
  localparam [5:0] ST_WORD = 6'b001000;
  localparam [5:0] ST_WACK = 6'b010000;
  localparam [5:0] ST_READ = 6'b100000;

  // ----------------------------------------
  // input filtering and edge detect
  // ----------------------------------------
  wire scl_f;
  wire sda_f;
  ppx_glitch_filter u_scl (.clock(clock), .rst_n(rst_n), .raw_in(scl_in), .filt_out(scl_f));
  ppx_glitch_filter u_sda (.clock(clock), .rst_n(rst_n), .raw_in(sda_in), .filt_out(sda_f));

  reg        scl_d_reg;
  reg        sda_d_reg;
  reg [5:0]  state_reg;
  reg [3:0]  bit_cnt_reg;
  reg [7:0]  shift_reg;
  reg        rw_reg;
  reg        drive_low_reg;
  reg [15:0] init_cnt_reg;
  reg [7:0]  nv_mem [0:15];
  reg [3:0]  load_idx_reg;
  reg        loading_reg;
  integer    i;

  // internal reset: pin reset or low supply [RL8]
  wire int_rst = !rst_n || low_supply;
  wire scl_rise = scl_f && !scl_d_reg;
  wire scl_fall = !scl_f && scl_d_reg;
  // start and stop are blind while our own driver holds data low [RL3] [RL4]
  wire start_det = scl_f && scl_d_reg && sda_d_reg && !sda_f && !drive_low_reg;
  wire stop_det  = scl_f && scl_d_reg && !sda_d_reg && sda_f && !drive_low_reg;

  function [7:0] reg_read;
    input [3:0] code;
    begin
      case (code)
        `PPX_ADDR_OUTPUT_PORT_CONTROL: reg_read = output_port_control_reg;
        `PPX_ADDR_TIMER_RANGE_SELECT:  reg_read = timer_range_select_reg;
        `PPX_ADDR_CHANNEL0_DELAY:      reg_read = channel0_delay_select_reg;
        `PPX_ADDR_CHANNEL1_DELAY:      reg_read = channel1_delay_select_reg;
        `PPX_ADDR_CHANNEL2_DELAY:      reg_read = channel2_delay_select_reg;
        `PPX_ADDR_CHANNEL3_DELAY:      reg_read = channel3_delay_select_reg;
        default:                       reg_read = 8'h00;
      endcase
    end
  endfunction

  // one selects the short range per channel [RL13]
  assign channel_short_range = timer_range_select_reg[3:0];
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low_reg;

  // ----------------------------------------
  // power-on init and nonvolatile reload
  // ----------------------------------------
  always @(posedge clock) begin
    if (int_rst) begin
      init_cnt_reg <= 16'h0000;
      init_done    <= 1'b0;
      loading_reg  <= 1'b0;
      load_idx_reg <= 4'h0;
    end else if (!init_done) begin
      if (!loading_reg) begin
        if (init_cnt_reg == INIT_CYCLES - 16'h0001) begin
          loading_reg <= 1'b1;
        end else begin
          init_cnt_reg <= init_cnt_reg + 16'h0001;
        end
      end else begin
        // copy every word before declaring standby [RL15]
        load_idx_reg <= load_idx_reg + 4'h1;
        if (load_idx_reg == 4'hF) begin
          init_done <= 1'b1; // standby [RL10]
        end
      end
    end
  end

  // ----------------------------------------
  // nonvolatile store and working registers
  // ----------------------------------------
  // nonvolatile store keeps its contents across pin reset; only power loses them,
  // so shipped values come from initial load here as the power-up image
  initial begin
    for (i = 0; i < 16; i = i + 1) begin
      nv_mem[i] = `PPX_RST_CHANNEL_DELAY; // [RL12]
    end
    nv_mem[`PPX_ADDR_OUTPUT_PORT_CONTROL] = `PPX_RST_OUTPUT_PORT_CONTROL; // [RL12]
    nv_mem[`PPX_ADDR_TIMER_RANGE_SELECT]  = `PPX_RST_TIMER_RANGE_SELECT; // [RL12]
  end

  wire wr_en = (state_reg == ST_WACK) && scl_fall && !rw_reg;

  always @(posedge clock) begin
    if (wr_en) begin
      nv_mem[shift_reg[`PPX_CODE_MSB:`PPX_CODE_LSB]] <= shift_reg[7:0];
    end
  end

  always @(posedge clock) begin
    if (int_rst) begin
      output_port_control_reg   <= 8'h00;
      timer_range_select_reg    <= 8'h00;
      channel0_delay_select_reg <= 8'h00;
      channel1_delay_select_reg <= 8'h00;
      channel2_delay_select_reg <= 8'h00;
      channel3_delay_select_reg <= 8'h00;
    end else if (loading_reg && !init_done) begin
      case (load_idx_reg)
        `PPX_ADDR_OUTPUT_PORT_CONTROL: output_port_control_reg <= nv_mem[load_idx_reg];
        `PPX_ADDR_TIMER_RANGE_SELECT:  timer_range_select_reg <= nv_mem[load_idx_reg];
        `PPX_ADDR_CHANNEL0_DELAY:      channel0_delay_select_reg <= nv_mem[load_idx_reg]; // [RL14]
        `PPX_ADDR_CHANNEL1_DELAY:      channel1_delay_select_reg <= nv_mem[load_idx_reg];
        `PPX_ADDR_CHANNEL2_DELAY:      channel2_delay_select_reg <= nv_mem[load_idx_reg];
        `PPX_ADDR_CHANNEL3_DELAY:      channel3_delay_select_reg <= nv_mem[load_idx_reg];
        default: ;
      endcase
    end else if (wr_en) begin
      case (shift_reg[`PPX_CODE_MSB:`PPX_CODE_LSB])
        `PPX_ADDR_OUTPUT_PORT_CONTROL: output_port_control_reg <= shift_reg;
        `PPX_ADDR_TIMER_RANGE_SELECT:  timer_range_select_reg <= shift_reg;
        `PPX_ADDR_CHANNEL0_DELAY:      channel0_delay_select_reg <= shift_reg;
        `PPX_ADDR_CHANNEL1_DELAY:      channel1_delay_select_reg <= shift_reg;
        `PPX_ADDR_CHANNEL2_DELAY:      channel2_delay_select_reg <= shift_reg;
        `PPX_ADDR_CHANNEL3_DELAY:      channel3_delay_select_reg <= shift_reg;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  always @(posedge clock) begin
    if (int_rst) begin
      // release data and idle until a start [RL16] [RL8]
      scl_d_reg     <= 1'b1;
      sda_d_reg     <= 1'b1;
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      rw_reg        <= 1'b0;
      drive_low_reg <= 1'b0;
    end else begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
      if (!init_done) begin
        // bus ignored during initialization [RL9]
        state_reg     <= ST_IDLE;
        drive_low_reg <= 1'b0;
      end else if (start_det) begin
        state_reg   <= ST_ADDR; // [RL1]
        bit_cnt_reg <= 4'h0;
      end else if (stop_det) begin
        state_reg   <= ST_IDLE; // [RL1] [RL6]
        bit_cnt_reg <= 4'h0;
      end else begin
        // no start or stop: state only moves on clock edges, so a cut transfer
        // holds where it was until recovery clocks walk it out [RL2] [RL5]
        case (state_reg)
          ST_IDLE: begin
            drive_low_reg <= 1'b0;
          end
          ST_ADDR, ST_WORD: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_f};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                rw_reg <= shift_reg[0];
                if (shift_reg[7:1] == DEV_ADDR) begin
                  drive_low_reg <= 1'b1;
                  state_reg     <= ST_AACK;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else begin
                drive_low_reg <= 1'b1;
                state_reg     <= ST_WACK;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              if (rw_reg) begin
                shift_reg     <= reg_read(`PPX_ADDR_OUTPUT_PORT_CONTROL);
                drive_low_reg <= !output_port_control_reg[7];
                state_reg     <= ST_READ;
              end else begin
                drive_low_reg <= 1'b0;
                state_reg     <= ST_WORD;
              end
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              drive_low_reg <= 1'b0;
              state_reg     <= ST_IDLE;
            end
          end
          ST_READ: begin
            // each falling edge shifts out; data released after the eighth bit
            if (scl_fall) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              shift_reg   <= {shift_reg[6:0], 1'b1};
              if (bit_cnt_reg == 4'h7) begin
                drive_low_reg <= 1'b0;
                state_reg     <= ST_IDLE;
              end else begin
                drive_low_reg <= !shift_reg[6];
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [design/ppx_map.vh]
// register map, reset values and timing constants of the port expander slave
`ifndef PPX_MAP_VH
`define PPX_MAP_VH
// word codes
`define PPX_ADDR_OUTPUT_PORT_CONTROL  4'h5
`define PPX_ADDR_TIMER_RANGE_SELECT   4'h6
`define PPX_ADDR_CHANNEL0_DELAY       4'h8
`define PPX_ADDR_CHANNEL1_DELAY       4'h9
`define PPX_ADDR_CHANNEL2_DELAY       4'hA
`define PPX_ADDR_CHANNEL3_DELAY       4'hB
// shipped memory contents
`define PPX_RST_OUTPUT_PORT_CONTROL   8'hD4
`define PPX_RST_TIMER_RANGE_SELECT    8'hFF
`define PPX_RST_CHANNEL_DELAY         8'h00
// field positions
`define PPX_CODE_MSB                  3
`define PPX_CODE_LSB                  0
// timing
`define PPX_CLK_PERIOD_NS             20
`define PPX_GLITCH_NS                 130
`define PPX_GLITCH_CYCLES             ((`PPX_GLITCH_NS + `PPX_CLK_PERIOD_NS - 1) / `PPX_CLK_PERIOD_NS)
`define PPX_INIT_CYCLES_DEF           64
`define PPX_RECOVERY_CLOCKS           27
`endif

// [design/ppx_glitch_filter.v]
// glitch filter for one bus input: a new level must hold for the filter span
`timescale 1ns/1ps
`default_nettype none
`include "ppx_map.vh"
module ppx_glitch_filter (
  // clock and reset
  input  wire       clock,
  input  wire       rst_n,
  // raw and filtered level
  input  wire       raw_in,
  output reg        filt_out
);
  // last count of the filter span, cut to the counter width on purpose
  localparam [31:0] SPAN_LAST = `PPX_GLITCH_CYCLES - 1;
  reg [3:0] cnt_reg;
  reg       sync0_reg;
  reg       sync1_reg;

  always @(posedge clock) begin
    if (!rst_n) begin
      sync0_reg <= 1'b1;
      sync1_reg <= 1'b1;
      cnt_reg   <= 4'h0;
      filt_out  <= 1'b1;
    end else begin
      sync0_reg <= raw_in;
      sync1_reg <= sync0_reg;
      // pulses shorter than the span never reach the protocol logic [RL11]
      if (sync1_reg == filt_out) begin
        cnt_reg <= 4'h0;
      end else if (cnt_reg == SPAN_LAST[3:0]) begin
        cnt_reg  <= 4'h0;
        filt_out <= sync1_reg;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/ppx_i2c_slave_checker.sv]
// concurrent checks on the port expander slave ports
`timescale 1ns/1ps
`default_nettype none
module ppx_chk #(
  parameter [15:0] INIT_CYCLES = 16'h0040
) (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       low_supply,
  // bus and status
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_oe,
  input wire logic       init_done,
  input wire logic [7:0] timer_range_select_reg,
  input wire logic [3:0] channel_short_range
);
  // edges since the last internal reset; saturates so it never wraps
  logic [15:0] up_cnt;
  always @(posedge clock) begin
    if (!rst_n || low_supply) up_cnt <= 16'h0000;
    else if (up_cnt != 16'hffff) up_cnt <= up_cnt + 16'h0001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_gap; !init_done |-> !sda_oe; endproperty
  a_gap: assert property (p_gap) else $error("data driven before init");
  property p_clr; disable iff (1'b0) !rst_n |=> !sda_oe && !init_done; endproperty
  a_clr: assert property (p_clr) else $error("reset left bus or status");
  property p_low; low_supply |=> !init_done && !sda_oe; endproperty
  a_low: assert property (p_low) else $error("low supply did not reset");
  property p_span; init_done |-> up_cnt >= INIT_CYCLES; endproperty
  a_span: assert property (p_span) else $error("init finished too early");
  // reload is short; forty edges of slack over the wait
  property p_bnd; up_cnt >= INIT_CYCLES + 40 |-> init_done; endproperty
  a_bnd: assert property (p_bnd) else $error("init never finished");
  property p_rng; channel_short_range == timer_range_select_reg[3:0]; endproperty
  a_rng: assert property (p_rng) else $error("short range mismatch");
  property p_hold; disable iff (!rst_n || low_supply) $rose(sda_oe) |-> sda_oe [*8]; endproperty
  a_hold: assert property (p_hold) else $error("data drive too short");
  property p_seize; disable iff (!rst_n || low_supply) sda_oe && scl_in |=> sda_oe; endproperty
  a_seize: assert property (p_seize) else $error("drive dropped in clock high");
  property p_edge; !$past(low_supply) && $changed(sda_oe) |-> !scl_in; endproperty
  a_edge: assert property (p_edge) else $error("data drive moved in clock high");
  property p_stop;
    disable iff (!rst_n || low_supply) scl_in && $rose(sda_in) && !sda_oe |=> !sda_oe [*8];
  endproperty
  a_stop: assert property (p_stop) else $error("drive right after stop");
  c_ack: cover property ($rose(sda_oe));
  c_init: cover property ($rose(init_done));
  c_low: cover property (low_supply);
endmodule
bind ppx_i2c_slave ppx_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
  .clock, .rst_n, .low_supply, .scl_in, .sda_in, .sda_oe, .init_done,
  .timer_range_select_reg, .channel_short_range
);
`default_nettype wire

// [testbench/ppx_i2c_master_model.sv]
// i2c master model driving clock and data toward the slave
`timescale 1ns/1ps
`default_nettype none
module ppx_i2c_master_model (
  // clock
  input  wire logic clock,
  // bus lines
  output var logic  scl,
  output var logic  sda_drv,
  input  wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic start;
    sda_drv <= 1'b1;
    wt(10);
    scl <= 1'b1;
    wt(20);
    sda_drv <= 1'b0;
    wt(20);
    scl <= 1'b0;
    wt(10);
  endtask
  task automatic stop;
    sda_drv <= 1'b0;
    wt(10);
    scl <= 1'b1;
    wt(20);
    sda_drv <= 1'b1;
    wt(20);
  endtask
  // data moves half way through clock low, clear of the slave's filter lag
  task automatic bitx(input logic b, output logic r);
    sda_drv <= b;
    wt(10);
    scl <= 1'b1;
    wt(20);
    r = sda_line;
    scl <= 1'b0;
    wt(10);
  endtask
  task automatic glitch;
    scl <= 1'b1;
    wt(3);
    scl <= 1'b0;
    wt(10);
  endtask
  task automatic bytex(input logic [7:0] d, output logic [7:0] q, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(1'b1, r);
    ak = !r;
  endtask
  task automatic recover;
    logic r;
    start;
    repeat (27) bitx(1'b1, r);
    stop;
  endtask
endmodule
`default_nettype wire

// [testbench/i2c_port_expander_recovery_init_tb_top.sv]
// self-checking bench for the port expander slave
`timescale 1ns/1ps
`default_nettype none
`include "ppx_map.vh"
module i2c_port_expander_recovery_init_tb_top;
  localparam logic [6:0] ADDR = 7'h2A;
  logic       clock, rst_n, low_supply, scl, sda_drv;
  logic [7:0] r_ctl, r_rng, r_c0, r_c1, r_c2, r_c3;
  logic [3:0] shr;
  wire logic  sda_oe, init_done;
  wire logic  sda_line = sda_drv & ~sda_oe;
  int         err_total, checks;
  ppx_i2c_slave #(.DEV_ADDR(ADDR), .INIT_CYCLES(16'h0258)) u_dut (
    .clock, .rst_n, .low_supply, .scl_in(scl), .sda_in(sda_line), .sda_out(),
    .sda_oe, .init_done, .output_port_control_reg(r_ctl), .timer_range_select_reg(r_rng),
    .channel0_delay_select_reg(r_c0), .channel1_delay_select_reg(r_c1),
    .channel2_delay_select_reg(r_c2), .channel3_delay_select_reg(r_c3),
    .channel_short_range(shr)
  );
  ppx_i2c_master_model u_mst (.clock, .scl, .sda_drv, .sda_line);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    #1;
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
    // back onto the rising edge so the next drive stays edge aligned
    @(posedge clock);
  endtask
  task automatic end_sim;
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wait_init;
    int n = 0;
    while (init_done !== 1'b1 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    chk({7'h00, init_done}, 8'h01);
  endtask
  task automatic wr(input logic [7:0] d, input logic g);
    logic [7:0] q;
    logic       ak;
    u_mst.start;
    if (g) u_mst.glitch;
    u_mst.bytex({ADDR, 1'b0}, q, ak);
    chk({7'h00, ak}, 8'h01);
    u_mst.bytex(d, q, ak);
    chk({7'h00, ak}, 8'h01);
    u_mst.stop;
  endtask
  task automatic t_init;
    wait_init;
    chk(r_ctl, `PPX_RST_OUTPUT_PORT_CONTROL);
    chk(r_rng, `PPX_RST_TIMER_RANGE_SELECT);
    chk(r_c0 | r_c1 | r_c2 | r_c3, `PPX_RST_CHANNEL_DELAY);
    chk({4'h0, shr}, 8'h0f);
  endtask
  task automatic t_write;
    wr(8'h35, 1'b1);
    chk(r_ctl, 8'h35);
    wr(8'h16, 1'b0);
    chk({4'h0, shr}, 8'h06);
    wr(8'h08, 1'b0);
    chk(r_c0, 8'h08);
    wr(8'h0b, 1'b0);
    chk(r_c3, 8'h0b);
  endtask
  // a read cut short leaves the slave pulling data low until clocked out
  task automatic t_recover;
    logic [7:0] q;
    logic       ak;
    u_mst.start;
    u_mst.bytex({ADDR, 1'b1}, q, ak);
    wt(200);
    chk({7'h00, sda_oe}, 8'h01);
    u_mst.start;
    wt(5);
    chk({7'h00, sda_oe}, 8'h01);
    u_mst.recover;
    chk({7'h00, sda_oe}, 8'h00);
    wr(8'h35, 1'b0);
  endtask
  task automatic t_lowsup;
    logic [7:0] q;
    logic       ak;
    low_supply <= 1'b1;
    wt(2);
    low_supply <= 1'b0;
    chk(r_ctl, 8'h00);
    chk({7'h00, init_done}, 8'h00);
    u_mst.start;
    u_mst.bytex({ADDR, 1'b0}, q, ak);
    chk({7'h00, ak}, 8'h00);
    u_mst.stop;
    wait_init;
    chk(r_ctl, 8'h35);
    chk(r_c0, 8'h08);
  endtask
  initial begin
    rst_n = 1'b0;
    low_supply = 1'b0;
    err_total = 0;
    checks = 0;
    wt(20);
    rst_n <= 1'b1;
    t_init;
    t_write;
    t_recover;
    t_lowsup;
    end_sim;
  end
  initial begin
    wt(40000);
    err_total++;
    end_sim;
  end
endmodule
`default_nettype wire
